// file: pkg/psc_regs.vh
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
// register index and byte address (index times four)
`define PSC_CTRL_INDEX        8'h11
`define PSC_CTRL_ADDR         8'h44
`define PSC_STATUS_ADDR       8'h48
// control field positions
`define PSC_PLL_OFF_BIT       15
`define PSC_SAVE_EN_BIT       14
`define PSC_MODE_HI           13
`define PSC_MODE_LO           12
`define PSC_SCR_BYP_BIT       11
`define PSC_FIFO_HI           9
`define PSC_FIFO_LO           8
`define PSC_FD_COL_BIT        4
`define PSC_IRQ_POL_BIT       3
`define PSC_TINT_BIT          2
`define PSC_IRQ_EN_BIT        1
`define PSC_IRQ_OE_BIT        0
// writable bits: 15..11, 9..8, 4..0
`define PSC_CTRL_WMASK        16'hFB1F
`define PSC_CTRL_RESET        16'h0108
// power modes
`define PSC_MODE_NORMAL       2'h0
`define PSC_MODE_PDOWN        2'h1
`define PSC_MODE_ASLEEP       2'h2
`define PSC_MODE_PSLEEP       2'h3
// link pulse interval in active sleep
`define PSC_NLP_MS            1400
`define PSC_CLK_MHZ           100
`define PSC_NLP_CYCLES        (`PSC_NLP_MS * 1000 * `PSC_CLK_MHZ)
// axi responses
`define PSC_RESP_OKAY         2'h0
`define PSC_RESP_SLVERR       2'h2
`endif

// file: hw/psc_power_fsm.v
`timescale 1ns/1ps
`include "psc_regs.vh"
// power state sequencer: applies mode, wakes on energy, paces link pulses
module psc_power_fsm #(
  parameter NLP_CYCLES = `PSC_NLP_CYCLES
) (
  input  wire       clock,
  input  wire       reset,
  input  wire       clock_enable,
  input  wire       save_en,       // power save enable
  input  wire [1:0] mode,          // requested power mode
  input  wire       mode_write,    // control register written this cycle
  input  wire       energy,        // synchronised energy detect
  output reg  [1:0] state,         // effective power state
  output reg        nlp_pulse      // one-cycle link pulse request
);
  localparam ST_RUN    = 2'h0;
  localparam ST_PDOWN  = 2'h1;
  localparam ST_ASLEEP = 2'h2;
  localparam ST_PSLEEP = 2'h3;

  reg [31:0] nlp_count;            // cycles since last link pulse
  reg [1:0]  next_state;
  reg        woken;                // latched wake until software rewrites

  // pick next state from mode, enable and wake
  always @*
  begin
    next_state = ST_RUN;
    if (save_en && !woken)
    begin
      case (mode)
        `PSC_MODE_NORMAL: next_state = ST_RUN;               // R2
        `PSC_MODE_PDOWN:  next_state = ST_PDOWN;             // R3
        `PSC_MODE_ASLEEP: next_state = energy ? ST_RUN : ST_ASLEEP; // R5
        `PSC_MODE_PSLEEP: next_state = energy ? ST_RUN : ST_PSLEEP; // R6
        default:          next_state = ST_RUN;
      endcase
    end
  end // R7: enable clear keeps run

  // state, wake latch and pulse timer
  always @(posedge clock)
  begin
    if (reset)
    begin
      state     <= ST_RUN;
      woken     <= 1'b0;
      nlp_count <= 32'h00000000;
      nlp_pulse <= 1'b0;
    end
    else if (clock_enable)
    begin
      state <= next_state;
      // a wake holds full power until software writes the register again;
      // a wake in the same cycle as a write wins, so energy is never missed
      if ((state == ST_ASLEEP || state == ST_PSLEEP) && energy)
        woken <= 1'b1; // R5 R6
      else if (mode_write)
        woken <= 1'b0;
      nlp_pulse <= 1'b0;
      if (state == ST_ASLEEP)
      begin
        if (nlp_count >= NLP_CYCLES - 1)
        begin
          nlp_count <= 32'h00000000;
          nlp_pulse <= 1'b1; // R4
        end
        else
          nlp_count <= nlp_count + 32'h00000001;
      end
      else
        nlp_count <= 32'h00000000; // no pulses outside active sleep R6
    end
  end
endmodule

// file: hw/psc_top.v
`timescale 1ns/1ps
`include "psc_regs.vh"
//Function
//R1: PLL off only in IEEE power-down
//R2: mode 00 runs fully functional
//R3: mode 01 shuts all but management
//R4: active sleep sends pulse every 1.4s
//R5: active sleep wakes on energy
//R6: passive sleep silent, wakes on energy
//R7: mode applies only with save enable
//R8: scrambler bypass skips 100M scrambling
//R9: reserved bits read zero, ignore writes
//R10: depth code selects 4,5,6,8 nibbles
//R11: loopback passes nibbles through elastic FIFO
//R12: depth resets to five nibbles
//R13: software sizes depth for packets, tolerance
//R14: collision enable gives full-duplex collision
//R15: otherwise collision only in half duplex
//R16: interrupt polarity bit, resets to one
module psc_top #(
  parameter NLP_CYCLES = `PSC_NLP_CYCLES
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        clock_enable,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        energy_detect,   // pin, asynchronous
  input  wire        full_duplex,     // link is full duplex, same clock
  input  wire        collision_raw,   // raw collision from medium, same clock
  input  wire        irq_event,       // event interrupt request, same clock
  output reg  [1:0]  power_state,     // effective power state
  output reg         analog_power_on, // analog and pcs circuitry powered
  output reg         pll_disable,     // internal clock circuits off
  output reg         nlp_send,        // one-cycle normal link pulse request
  output reg         scrambler_bypass,
  output reg  [3:0]  loopback_depth,  // fifo depth in nibbles
  output reg         mac_collision,   // collision shown to mac
  output reg         irq_out,         // interrupt pin level
  output reg         irq_out_enable   // pin acts as interrupt output
);
  // one 16-bit control image drives every output below; reserved bit
  // positions are masked on each write, so they can never read back as one
  // the bus side and the datapath side share the image but only the bus
  // side writes it, which keeps a single driver per bit
  // outputs are all registered, so the datapath sees a change one cycle
  // after the image changes, two for the power outputs; nothing here is combinational to a pin
  reg [15:0] ctrl;          // control register image
  reg        energy_meta;   // synchroniser first stage
  reg        energy_sync;   // synchroniser second stage
  reg        aw_held;       // write address taken
  reg        w_held;        // write data taken
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [15:0] next_ctrl;
  reg        ctrl_write;
  wire [1:0] fsm_state;
  wire       fsm_pulse;

  // depth code to nibble count
  // the code is not a plain binary count: the top code jumps to eight,
  // so it is decoded here rather than added to a base value
  // all four codes are legal, so there is no refused setting to handle
  function [3:0] depth_nibbles;
    input [1:0] code;
    begin
      case (code)
        2'h0:    depth_nibbles = 4'h4;
        2'h1:    depth_nibbles = 4'h5;
        2'h2:    depth_nibbles = 4'h6;
        default: depth_nibbles = 4'h8;
      endcase
    end
  endfunction

  // read image with reserved bits forced low
  // the image is masked again on the way out as a second guard; the status
  // word only shows the effective power state, which may differ from the
  // requested mode after a wake on energy
  // unmapped words read as zero and the response carries the error
  // limitation: only the low half word is mapped, the upper half reads zero
  function [31:0] read_word;
    input [7:0]  addr;
    input [15:0] c;
    input [1:0]  st;
    begin
      if (addr[7:2] == `PSC_CTRL_ADDR >> 2)
        read_word = {16'h0000, c & `PSC_CTRL_WMASK}; // R9
      else if (addr[7:2] == `PSC_STATUS_ADDR >> 2)
        read_word = {30'h00000000, st};
      else
        read_word = 32'h00000000;
    end
  endfunction

  // energy detect crosses in from the line side
  // two flops before any logic reads it; only the second stage is used,
  // so a metastable first stage never reaches the power sequencer
  // the price is two cycles of extra wake latency, far below any link need
  always @(posedge clock)
  begin
    if (reset)
    begin
      energy_meta <= 1'b0;
      energy_sync <= 1'b0;
    end
    else if (clock_enable)
    begin
      energy_meta <= energy_detect;
      energy_sync <= energy_meta;
    end
  end

  // merge byte lanes into the control image
  // only the two low strobes matter, since the register is one half word
  // an illegal clock-off request is dropped silently rather than refused,
  // so the rest of the same write still lands
  // the check uses the value being written, not the old image, so one write
  // may enter power-down and stop the clock circuits together
  always @*
  begin
    next_ctrl  = ctrl;
    // a write lands only once both halves are held and before the response
    ctrl_write = aw_held && w_held && !s_axi_bvalid
                 && (aw_addr[7:2] == `PSC_CTRL_ADDR >> 2);
    if (w_strb[0])
      next_ctrl[7:0] = w_data[7:0];
    if (w_strb[1])
      next_ctrl[15:8] = w_data[15:8];
    next_ctrl = next_ctrl & `PSC_CTRL_WMASK; // R9
    // pll may only stop in IEEE power-down; refuse it elsewhere
    if (!(next_ctrl[`PSC_SAVE_EN_BIT]
          && next_ctrl[`PSC_MODE_HI:`PSC_MODE_LO] == `PSC_MODE_PDOWN))
      next_ctrl[`PSC_PLL_OFF_BIT] = 1'b0; // R1
  end

  // axi write channel: address and data in either order
  // each ready is a one-cycle pulse raised the cycle after its valid is seen;
  // the channel that is taken first is held until the other arrives
  // the response is raised the cycle after both are held and the image is
  // updated on that same edge, so a read issued after the response always
  // sees the new value
  // a second address or data word is not taken until the response has been
  // accepted, which keeps at most one write in flight
  // the status word is read-only, so a write to it only earns an error
  always @(posedge clock)
  begin
    if (reset)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSC_RESP_OKAY;
      ctrl          <= `PSC_CTRL_RESET; // R12 R16
    end
    else if (clock_enable)
    begin
      // ready pulses for one cycle, then waits for the next transfer
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        // status word is read-only; unmapped gets slverr
        s_axi_bresp  <= (aw_addr[7:2] == `PSC_CTRL_ADDR >> 2) ?
                        `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
        if (ctrl_write)
          ctrl <= next_ctrl;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // axi read channel, answers in power-down too
  // the read path never depends on the power state, so management access
  // survives every low-power mode
  // ready is a one-cycle pulse; a new address waits while data is pending,
  // which keeps one read in flight and the returned word stable until taken
  always @(posedge clock)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PSC_RESP_OKAY;
    end
    else if (clock_enable)
    begin
      // one-cycle ready, held off while read data is pending
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1; // R3
        s_axi_rdata  <= read_word(s_axi_araddr, ctrl, fsm_state);
        s_axi_rresp  <= (s_axi_araddr[7:2] == `PSC_CTRL_ADDR >> 2
                         || s_axi_araddr[7:2] == `PSC_STATUS_ADDR >> 2) ?
                        `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // power mode sequencing lives in its own module
  // the sequencer is told of every control write so a wake latched on energy
  // is released only by software; a stale wake never outlives a rewrite
  // the pulse interval is a parameter so simulation can shorten it
  // the sequencer shares the clock enable, so a frozen block stays asleep
  psc_power_fsm #(
    .NLP_CYCLES (NLP_CYCLES)
  ) u_power (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .save_en      (ctrl[`PSC_SAVE_EN_BIT]),
    .mode         (ctrl[`PSC_MODE_HI:`PSC_MODE_LO]),
    .mode_write   (ctrl_write && aw_held && w_held && !s_axi_bvalid),
    .energy       (energy_sync),
    .state        (fsm_state),
    .nlp_pulse    (fsm_pulse)
  );

  // registered outputs to the datapath
  // every output comes straight from a flop here, so the datapath never
  // sees a glitch while the image or the power state changes
  // analog power follows the effective state, not the requested mode, so a
  // wake on energy restores power without waiting for software
  // clock-off also waits for the effective state, which guards against a
  // wake racing the write that asked for power-down
  always @(posedge clock)
  begin
    if (reset)
    begin
      // reset values match the image defaults
      power_state      <= `PSC_MODE_NORMAL;
      analog_power_on  <= 1'b1;
      pll_disable      <= 1'b0;
      nlp_send         <= 1'b0;
      scrambler_bypass <= 1'b0;
      loopback_depth   <= 4'h5;
      mac_collision    <= 1'b0;
      irq_out          <= 1'b1;
      irq_out_enable   <= 1'b0;
    end
    else if (clock_enable)
    begin
      power_state      <= fsm_state;
      analog_power_on  <= (fsm_state == `PSC_MODE_NORMAL); // R2 R3
      pll_disable      <= ctrl[`PSC_PLL_OFF_BIT]
                          && fsm_state == `PSC_MODE_PDOWN; // R1
      nlp_send         <= fsm_pulse; // R4
      scrambler_bypass <= ctrl[`PSC_SCR_BYP_BIT]; // R8
      loopback_depth   <= depth_nibbles(ctrl[`PSC_FIFO_HI:`PSC_FIFO_LO]); // R10 R11
      // collision and interrupt inputs are on this clock already, so they
      // go straight into the output flops with a single cycle of latency
      // full duplex masks collision unless enabled
      mac_collision    <= collision_raw
                          && (!full_duplex || ctrl[`PSC_FD_COL_BIT]); // R14 R15
      // test interrupt forces the active level whether or not events are on
      // polarity: set means idle high, asserted low
      irq_out          <= ctrl[`PSC_IRQ_POL_BIT]
                          ^ (ctrl[`PSC_TINT_BIT]
                             || (ctrl[`PSC_IRQ_EN_BIT] && irq_event)); // R16
      irq_out_enable   <= ctrl[`PSC_IRQ_OE_BIT];
    end
  end
endmodule

// file: test/psc_top_asserts.sv
`timescale 1ns/1ps
// power, collision and bus hold checks at the top ports
module psc_top_asserts (
  input wire        clock,
  input wire        reset,
  input wire        clock_enable,
  input wire        energy_detect,
  input wire        full_duplex,
  input wire        collision_raw,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  power_state,
  input wire        analog_power_on,
  input wire        pll_disable,
  input wire        nlp_send,
  input wire        scrambler_bypass,
  input wire [3:0]  loopback_depth,
  input wire        mac_collision,
  input wire        irq_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // reset itself is the cause here, so no disable
  a_reset_vals: assert property (disable iff (1'b0)
    reset && clock_enable |=> loopback_depth == 4'h5 && irq_out && !scrambler_bypass)
    else $error("defaults wrong after reset");
  a_pll_pdown: assert property (
    pll_disable |-> power_state == 2'h1 || $past(power_state) == 2'h1)
    else $error("clock circuits off outside power-down");
  // one cycle of slack for the two registered outputs
  a_analog_run: assert property (
    clock_enable && $stable(power_state) |-> analog_power_on == (power_state == 2'h0))
    else $error("analog power disagrees with state");
  a_nlp_sleep: assert property (
    nlp_send |-> power_state == 2'h2 || $past(power_state) == 2'h2)
    else $error("link pulse outside active sleep");
  a_nlp_single: assert property (nlp_send && clock_enable |=> !nlp_send)
    else $error("link pulse longer than one cycle");
  a_wake_energy: assert property (
    (power_state[1] && clock_enable && energy_detect) [*4] |=> power_state == 2'h0)
    else $error("no wake on energy");
  a_depth_code: assert property (loopback_depth inside {4'h4, 4'h5, 4'h6, 4'h8})
    else $error("illegal loopback depth");
  a_coll_half: assert property (
    clock_enable && collision_raw && !full_duplex |=> mac_collision)
    else $error("half duplex collision lost");
  a_coll_quiet: assert property (clock_enable && !collision_raw |=> !mac_collision)
    else $error("collision without cause");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  c_pulse: cover property (nlp_send);
  c_pll: cover property (pll_disable);
  c_fd_coll: cover property (mac_collision && full_duplex);
endmodule
bind psc_top psc_top_asserts i_psc_top_asserts (.clock, .reset, .clock_enable, .energy_detect,
  .full_duplex, .collision_raw, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .power_state, .analog_power_on, .pll_disable, .nlp_send,
  .scrambler_bypass, .loopback_depth, .mac_collision, .irq_out);

// file: test/psc_mgmt_master.sv
`timescale 1ns/1ps
// management controller: one access at a time, each channel held to its ready
module psc_mgmt_master (
  input  wire        clock,
  output reg  [7:0]  s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  output reg  [7:0]  s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  integer n;
  reg     pa, pw, pb;
  // idle bus at time zero; only the low half of a word matters
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h3;
  end
  // write; r stays 2'h1 when no answer comes
  task wr(input [7:0] a, input [15:0] d, output [1:0] r);
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {pa, pw, pb} = 3'h7;
      r = 2'h1;
      for (n = 0; n < 50 && pb; n = n + 1)
      begin
        @(posedge clock);
        // released payload is inverted, never left looking valid
        if (pa && s_axi_awready)
        begin
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr <= ~a;
          pa = 1'b0;
        end
        if (pw && s_axi_wready)
        begin
          s_axi_wvalid <= 1'b0;
          s_axi_wdata <= ~s_axi_wdata;
          pw = 1'b0;
        end
        if (s_axi_bvalid)
        begin
          s_axi_bready <= 1'b0;
          r = s_axi_bresp;
          pb = 1'b0;
        end
      end
    end
  endtask
  // read; the bench watches the returned data
  task rd(input [7:0] a);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      {pa, pb} = 2'h3;
      for (n = 0; n < 50 && pb; n = n + 1)
      begin
        @(posedge clock);
        if (pa && s_axi_arready)
        begin
          s_axi_arvalid <= 1'b0;
          s_axi_araddr <= ~a;
          pa = 1'b0;
        end
        if (s_axi_rvalid)
        begin
          s_axi_rready <= 1'b0;
          pb = 1'b0;
        end
      end
    end
  endtask
endmodule

// file: test/psc_top_test.sv
`timescale 1ns/1ps
`include "psc_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module psc_top_test;
  localparam NLP = 20;  // short pulse pacing keeps the run brief
  localparam bit [15:0] TBL [0:6] = '{16'hD000, 16'h8000, 16'hA000, 16'hFFFF,
                                      16'h2000, 16'h1000, 16'h0000};
  reg         clock = 1'b0, reset = 1'b1, clock_enable = 1'b1;
  reg         energy_detect = 1'b0, full_duplex = 1'b0;
  reg         collision_raw = 1'b0, irq_event = 1'b0;
  wire [7:0]  s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb, loopback_depth;
  wire [1:0]  s_axi_bresp, s_axi_rresp, power_state;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire        analog_power_on, pll_disable, nlp_send, scrambler_bypass;
  wire        mac_collision, irq_out, irq_out_enable;
  integer     bad_count = 0, n_compared = 0, i, k, cnt;
  reg [33:0]  exp_q [$];  // expected {resp, data} per read
  reg [33:0]  got;
  reg [31:0]  rv;
  reg [15:0]  d;
  reg [1:0]   r;
  psc_top #(.NLP_CYCLES(NLP)) i_psc_top (.clock, .reset, .clock_enable, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .energy_detect, .full_duplex,
    .collision_raw, .irq_event, .power_state, .analog_power_on, .pll_disable, .nlp_send,
    .scrambler_bypass, .loopback_depth, .mac_collision, .irq_out, .irq_out_enable);
  psc_mgmt_master i_psc_mgmt_master (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
  initial forever #5 clock = ~clock;
  // random event requests every cycle
  always @(posedge clock) irq_event <= ^$urandom;
  // each returned read is matched against the oldest note
  always @(posedge clock)
    if (s_axi_rvalid && s_axi_rready)
    begin
      got = exp_q.pop_front();
      `CHK("read", got, {s_axi_rresp, s_axi_rdata})
    end
  // write a control value, read it back, check the decoded outputs
  task wchk(input [15:0] v);
    reg [15:0] e;
    begin
      e = v & `PSC_CTRL_WMASK;
      if (v[14:12] != 3'h5) e[15] = 1'b0;  // clock-off only with power-down
      i_psc_mgmt_master.wr(`PSC_CTRL_ADDR, v, r);
      `CHK("bresp", `PSC_RESP_OKAY, r)
      exp_q.push_back({2'h0, 16'h0000, e});
      i_psc_mgmt_master.rd(`PSC_CTRL_ADDR);
      `CHK("state", e[14] ? e[13:12] : 2'h0, power_state)
      `CHK("pll", e[15], pll_disable)
      `CHK("analog", !e[14] || e[13:12] == 2'h0, analog_power_on)
      `CHK("bypass", e[11], scrambler_bypass)
      `CHK("depth", e[9:8] == 2'h3 ? 4'h8 : {2'h1, e[9:8]}, loopback_depth)
      // event requests are random, so the level is only checked with events off
      if (!e[1]) `CHK("irq", e[3] ^ e[2], irq_out)
      `CHK("irq oe", e[0], irq_out_enable)
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // hang guard
  initial
  begin
    #900000;
    bad_count++;
    test_done;
  end
  initial
  begin
    rv = $urandom(32'h385E);
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    exp_q.push_back({2'h0, 16'h0000, `PSC_CTRL_RESET});
    i_psc_mgmt_master.rd(`PSC_CTRL_ADDR);
    `CHK("depth rst", 4'h5, loopback_depth)
    `CHK("irq rst", 1'b1, irq_out)
    // fixed corner values first, then random ones with every depth code
    for (i = 0; i < 19; i = i + 1)
    begin
      rv = $urandom;
      d = i < 7 ? TBL[i] : rv[15:0];
      if (i > 6 && i < 11) d[9:8] = i[1:0];
      wchk(d);
    end
    // active then passive sleep: pulse count, then wake on energy
    for (k = 0; k < 2; k = k + 1)
    begin
      wchk(k ? 16'h7108 : 16'h6108);
      cnt = 0;
      repeat (10 * NLP) @(posedge clock) cnt = cnt + nlp_send;
      `CHK("pulses", k ? 0 : 10, cnt)
      // with the clock enable low the sleep state must hold despite energy
      clock_enable <= 1'b0;
      energy_detect <= 1'b1;
      repeat (8) @(posedge clock);
      `CHK("frozen", k ? 2'h3 : 2'h2, power_state)
      clock_enable <= 1'b1;
      for (i = 0; i < 10 && power_state !== 2'h0; i = i + 1) @(posedge clock);
      `CHK("wake", 2'h0, power_state)
      energy_detect <= 1'b0;
    end
    // collision for every duplex and enable pairing
    for (k = 0; k < 4; k = k + 1)
    begin
      wchk({11'h008, k[1], 4'h8});
      full_duplex <= k[0];
      collision_raw <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK("collision", !k[0] || k[1], mac_collision)
      collision_raw <= 1'b0;
    end
    // refused places: status write, unmapped read; then a status read that is answered
    i_psc_mgmt_master.wr(`PSC_STATUS_ADDR, 16'hFFFF, r);
    `CHK("status wr", `PSC_RESP_SLVERR, r)
    exp_q.push_back({`PSC_RESP_SLVERR, 32'h0});
    i_psc_mgmt_master.rd(8'h80);
    exp_q.push_back({`PSC_RESP_OKAY, 32'h0});
    i_psc_mgmt_master.rd(`PSC_STATUS_ADDR);
    repeat (2) @(posedge clock);
    `CHK("reads left", 0, exp_q.size())
    test_done;
  end
endmodule
